/* hw/clk_align_pkg.sv */
// Purpose: Shared constants for the output alignment and reset control
// Assumes: 100 MHz clock equals the channel-divider input clock
// Notes: Offsets are byte addresses on a 32-bit Wishbone bus
`default_nettype none
package clk_align_pkg;
	localparam int NCH = 4;
	localparam int NOUT = 12;
	localparam int OUT_PER_CH = 3;
	localparam logic [7:0] SERCTL_OFF = 8'h00;
	localparam logic [7:0] CTRL_OFF = 8'h04;
	localparam logic [7:0] UPDATE_OFF = 8'h08;
	localparam logic [7:0] STATUS_OFF = 8'h0C;
	localparam logic [7:0] CHAN_BASE = 8'h10;
	localparam logic [7:0] OUT_BASE = 8'h40;
	localparam int SC_SRST_LO = 2;
	localparam int SC_SRST_HI = 5;
	localparam int CT_SOFT_ALIGN = 0;
	localparam int CT_DIST_PD = 1;
	localparam int CH_HI_LSB = 0;
	localparam int CH_LO_LSB = 4;
	localparam int CH_DLY_LSB = 8;
	localparam int CH_INIT_HI = 12;
	localparam int CH_IGNORE = 13;
	localparam int CH_PD = 14;
	localparam int OC_PD = 0;
	localparam int OC_SWING_LSB = 1;
	localparam int OC_INV = 3;
	localparam int OC_SE = 4;
	localparam int OC_EN_A = 5;
	localparam int OC_EN_B = 6;
	localparam int OC_INV_B = 7;
	localparam logic [7:0] SERCTL_RST = 8'h00;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [14:0] CHAN_RST = 15'h0000;
	localparam logic [7:0] OUT_RST = 8'h04;
	localparam int CLK_HZ = 100_000_000;
	localparam int POR_ALIGN_MS = 50;
	localparam int POR_RUN_MS = 70;
	localparam int LOAD_MS = 20;
	localparam int QUICK_US = 2;
	localparam int POR_ALIGN_CYC = POR_ALIGN_MS * (CLK_HZ / 1000);
	localparam int POR_RUN_CYC = POR_RUN_MS * (CLK_HZ / 1000);
	localparam int LOAD_CYC = LOAD_MS * (CLK_HZ / 1000);
	localparam int QUICK_CYC = QUICK_US * (CLK_HZ / 1_000_000);
	localparam int ALIGN_PIPE_CYC = 14;
	localparam int ALIGN_EXTRA_CYC = 1;
	localparam int PIPE_CYC = ALIGN_PIPE_CYC + ALIGN_EXTRA_CYC;
	typedef enum logic [2:0] {
		S_BOOT = 3'h1,
		S_RUN = 3'h2,
		S_LOAD = 3'h4
	} seq_t;
endpackage
`default_nettype wire

/* hw/out_align_ctrl.sv */
// Purpose: Output alignment, driver enables and reset sequencing
// Assumes: clk_i is the channel-divider input clock; pins synchronous
// Notes: Storage contents are modelled as the built-in defaults
//
// What this block does
// RULE1: Alignment request pin low, release aligns
// RULE2: Soft align, soft reset, distribution pd trigger
// RULE3: Chip reset pin pulse causes alignment
// RULE4: Sleep pin pulse causes alignment on exit
// RULE5: Calibration holds internal alignment request
// RULE6: Outputs restart 14-15 cycles plus one
// RULE7: Request pin synchronised internally
// RULE8: Soft align changes only on update
// RULE9: Held outputs sit at preset static level
// RULE10: Every driver follows its channel divider
// RULE11: Ignoring channels keep running, unaligned
// RULE12: Per-output swing and polarity selection
// RULE13: Distribution power-down shuts all drivers
// RULE14: Safe power-down from three causes
// RULE15: Single-ended mode turns both drivers on
// RULE16: Enable bits gate single-ended drivers, tristate
// RULE17: Each single-ended output has own polarity
// RULE18: Storage select picks storage or defaults
// RULE19: Power-on align 50 ms, toggle 70 ms
// RULE20: Pin reset restores settings then aligns
// RULE21: Resume 20 ms with storage, else microseconds
// RULE22: Serial control bits 2 and 5 reset
// RULE23: Soft reset ends after one serial clock
// RULE24: Delay code from start-high and offset
// RULE25: Count fields hold cycles minus one
// RULE26: Alignment request is OR of sources
`default_nettype none
module out_align_ctrl #(
	parameter int POR_ALIGN_CYC = clk_align_pkg::POR_ALIGN_CYC,
	parameter int POR_RUN_CYC = clk_align_pkg::POR_RUN_CYC,
	parameter int LOAD_CYC = clk_align_pkg::LOAD_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic align_req_n_i,
	input wire logic chip_reset_n_i,
	input wire logic chip_sleep_pin_n_i,
	input wire logic storage_sel_i,
	input wire logic cal_busy_i,
	input wire logic sclk_tick_i,
	output logic [3:0] chan_clk_o,
	output logic [11:0] drv_on_o,
	output logic [11:0] drv_p_o,
	output logic [23:0] drv_swing_o,
	output logic [11:0] safe_off_o,
	output logic total_off_o,
	output logic [11:0] se_a_o,
	output logic [11:0] se_a_oe_o,
	output logic [11:0] se_b_o,
	output logic [11:0] se_b_oe_o,
	output logic align_busy_o,
	output logic storage_load_o
);
	localparam int NCH = clk_align_pkg::NCH;
	localparam int NOUT = clk_align_pkg::NOUT;

	if (POR_ALIGN_CYC < 1 || POR_ALIGN_CYC >= POR_RUN_CYC ||
	    POR_RUN_CYC >= 2 ** 24 || LOAD_CYC < 1 || LOAD_CYC >= 2 ** 24) begin
		$error("Timing parameters out of range");
	end

	logic [7:0] serctl_ff;
	logic [1:0] ctrl_ff;
	logic [1:0] act_ff;
	logic [14:0] chan_ff [NCH];
	logic [7:0] out_ff [NOUT];
	logic ack_ff;
	logic [31:0] dat_ff;
	logic [31:0] nxt_dat;
	logic pin_s1_ff, pin_s2_ff;
	logic rpin_ff, sleep_ff, cal_ff, store_ff;
	clk_align_pkg::seq_t state_ff;
	logic [23:0] cnt_ff;
	logic [4:0] pipe_ff;
	logic [NCH-1:0] lvl_ff;
	logic [NCH-1:0] held_w;

	logic acc, wr, upd, srst_pend, srst_fire, restore;
	logic chan_hit, out_hit, boot_src, any_src, hold_w;
	logic [1:0] chan_idx;
	logic [5:0] out_idx;
	assign acc = wb_cyc_i && wb_stb_i && !ack_ff;
	assign wr = acc && wb_we_i;
	assign chan_hit = wb_adr_i[7:4] == clk_align_pkg::CHAN_BASE[7:4];
	assign chan_idx = wb_adr_i[3:2];
	assign out_idx = wb_adr_i[7:2] - clk_align_pkg::OUT_BASE[7:2];
	assign out_hit = wb_adr_i[7:2] >= clk_align_pkg::OUT_BASE[7:2] &&
		out_idx < 6'(NOUT);
	assign upd = wr && wb_sel_i[0] && wb_dat_i[0] &&
		wb_adr_i == clk_align_pkg::UPDATE_OFF;
	assign srst_pend = serctl_ff[clk_align_pkg::SC_SRST_LO] &&
		serctl_ff[clk_align_pkg::SC_SRST_HI];
	assign srst_fire = srst_pend && sclk_tick_i; // RULE23
	assign restore = !rpin_ff || srst_fire; // RULE20 RULE22
	assign boot_src = state_ff == clk_align_pkg::S_BOOT &&
		cnt_ff < 24'(POR_ALIGN_CYC); // RULE19
	// Any live source keeps the included channels static
	assign any_src = !pin_s2_ff || act_ff[clk_align_pkg::CT_SOFT_ALIGN] ||
		act_ff[clk_align_pkg::CT_DIST_PD] || srst_pend || !rpin_ff ||
		!sleep_ff || cal_ff || boot_src ||
		state_ff == clk_align_pkg::S_LOAD; // RULE26 RULE2 RULE3 RULE4 RULE5
	assign hold_w = any_src || pipe_ff != 5'h00;

	// Two flops; only the second one is looked at
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_s1_ff <= 1'b1;
			pin_s2_ff <= 1'b1;
		end else begin
			pin_s1_ff <= align_req_n_i; // RULE7
			pin_s2_ff <= pin_s1_ff; // RULE1
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rpin_ff <= 1'b1;
			sleep_ff <= 1'b1;
			cal_ff <= 1'b0;
			store_ff <= 1'b0;
		end else begin
			rpin_ff <= chip_reset_n_i;
			sleep_ff <= chip_sleep_pin_n_i;
			cal_ff <= cal_busy_i;
			if (restore)
				store_ff <= storage_sel_i; // RULE18
		end
	end

	// Restart pipeline after the last source drops
	always_ff @(posedge clk_i) begin
		if (rst_i)
			pipe_ff <= 5'h00;
		else if (any_src)
			pipe_ff <= 5'(clk_align_pkg::PIPE_CYC); // RULE6
		else if (pipe_ff != 5'h00)
			pipe_ff <= pipe_ff - 5'h01;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= clk_align_pkg::S_BOOT;
			cnt_ff <= 24'h00_0000;
		end else if (restore) begin
			state_ff <= clk_align_pkg::S_LOAD;
			cnt_ff <= 24'h00_0000;
		end else begin
			case (state_ff)
			clk_align_pkg::S_BOOT: begin
				cnt_ff <= cnt_ff + 24'h00_0001;
				if (cnt_ff == 24'(POR_RUN_CYC - 1))
					state_ff <= clk_align_pkg::S_RUN; // RULE19
			end
			clk_align_pkg::S_LOAD: begin
				cnt_ff <= cnt_ff + 24'h00_0001;
				if (cnt_ff == (store_ff ? 24'(LOAD_CYC - 1) :
				    24'(clk_align_pkg::QUICK_CYC - 1)))
					state_ff <= clk_align_pkg::S_RUN; // RULE21
			end
			clk_align_pkg::S_RUN: cnt_ff <= 24'h00_0000;
			default: state_ff <= clk_align_pkg::S_BOOT;
			endcase
		end
	end

	// Serial control: bits 2 and 5 mirror each other
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			serctl_ff <= clk_align_pkg::SERCTL_RST;
		end else if (wr && wb_sel_i[0] &&
		    wb_adr_i == clk_align_pkg::SERCTL_OFF) begin
			serctl_ff <= wb_dat_i[7:0];
			if (wb_dat_i[clk_align_pkg::SC_SRST_LO] ||
			    wb_dat_i[clk_align_pkg::SC_SRST_HI]) begin
				serctl_ff[clk_align_pkg::SC_SRST_LO] <= 1'b1; // RULE22
				serctl_ff[clk_align_pkg::SC_SRST_HI] <= 1'b1;
			end
		end else if (srst_fire) begin
			serctl_ff[clk_align_pkg::SC_SRST_LO] <= 1'b0; // RULE23
			serctl_ff[clk_align_pkg::SC_SRST_HI] <= 1'b0;
		end
	end

	// Shadow control goes live only on the update strobe
	always_ff @(posedge clk_i) begin
		if (rst_i || restore) begin
			ctrl_ff <= clk_align_pkg::CTRL_RST;
			act_ff <= clk_align_pkg::CTRL_RST;
		end else begin
			if (wr && wb_sel_i[0] && wb_adr_i == clk_align_pkg::CTRL_OFF)
				ctrl_ff <= wb_dat_i[1:0];
			if (upd)
				act_ff <= ctrl_ff; // RULE8 RULE13
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || restore) begin
			for (int c = 0; c < NCH; c++)
				chan_ff[c] <= clk_align_pkg::CHAN_RST; // RULE20
			for (int i = 0; i < NOUT; i++)
				out_ff[i] <= clk_align_pkg::OUT_RST;
		end else if (wr && chan_hit) begin
			if (wb_sel_i[0])
				chan_ff[chan_idx][7:0] <= wb_dat_i[7:0];
			if (wb_sel_i[1])
				chan_ff[chan_idx][14:8] <= wb_dat_i[14:8];
		end else if (wr && out_hit && wb_sel_i[0]) begin
			out_ff[out_idx[3:0]] <= wb_dat_i[7:0];
			// Entering single-ended mode switches both on
			if (wb_dat_i[clk_align_pkg::OC_SE] &&
			    !out_ff[out_idx[3:0]][clk_align_pkg::OC_SE]) begin
				out_ff[out_idx[3:0]][clk_align_pkg::OC_EN_A] <= 1'b1; // RULE15
				out_ff[out_idx[3:0]][clk_align_pkg::OC_EN_B] <= 1'b1;
			end
		end
	end

	always_comb begin
		nxt_dat = 32'h0000_0000;
		if (chan_hit)
			nxt_dat = {17'h0_0000, chan_ff[chan_idx]};
		else if (out_hit)
			nxt_dat = {24'h00_0000, out_ff[out_idx[3:0]]};
		else begin
			case (wb_adr_i)
			clk_align_pkg::SERCTL_OFF: nxt_dat = {24'h00_0000, serctl_ff};
			clk_align_pkg::CTRL_OFF: nxt_dat = {28'h000_0000, act_ff, ctrl_ff};
			clk_align_pkg::STATUS_OFF:
				nxt_dat = {26'h000_0000, store_ff, state_ff, srst_pend, hold_w};
			default: nxt_dat = 32'h0000_0000;
			endcase
		end
	end

	// One wait state: ack in the cycle after the request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= acc;
			if (acc && !wb_we_i)
				dat_ff <= nxt_dat;
		end
	end
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;

	for (genvar c = 0; c < NCH; c++) begin : g_chan
		logic [4:0] cnt_c_ff;
		logic [5:0] dly_ff;
		logic [5:0] nxt_dly;
		logic [3:0] hi_w, lo_w;
		logic init_w;
		assign hi_w = chan_ff[c][clk_align_pkg::CH_HI_LSB +: 4];
		assign lo_w = chan_ff[c][clk_align_pkg::CH_LO_LSB +: 4];
		assign init_w = chan_ff[c][clk_align_pkg::CH_INIT_HI];
		assign held_w[c] = hold_w && !chan_ff[c][clk_align_pkg::CH_IGNORE]; // RULE11
		// Code 16 and up waits code-16 plus low count plus one
		assign nxt_dly = {2'h0, chan_ff[c][clk_align_pkg::CH_DLY_LSB +: 4]} +
			(init_w ? {2'h0, lo_w} + 6'h01 : 6'h00); // RULE24
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				lvl_ff[c] <= 1'b0;
				cnt_c_ff <= 5'h00;
				dly_ff <= 6'h00;
			end else if (held_w[c] || chan_ff[c][clk_align_pkg::CH_PD]) begin
				lvl_ff[c] <= init_w; // RULE9
				cnt_c_ff <= 5'h00;
				dly_ff <= nxt_dly;
			end else if (dly_ff != 6'h00) begin
				dly_ff <= dly_ff - 6'h01;
			end else if (cnt_c_ff == {1'b0, lvl_ff[c] ? hi_w : lo_w}) begin
				lvl_ff[c] <= !lvl_ff[c]; // RULE25
				cnt_c_ff <= 5'h00;
			end else begin
				cnt_c_ff <= cnt_c_ff + 5'h01;
			end
		end
		always_ff @(posedge clk_i) begin
			if (rst_i)
				chan_clk_o[c] <= 1'b0;
			else
				chan_clk_o[c] <= lvl_ff[c];
		end
	end

	for (genvar i = 0; i < NOUT; i++) begin : g_drv
		localparam int C = i / clk_align_pkg::OUT_PER_CH;
		logic off_w, tpd_w, val_w, se_w;
		assign off_w = out_ff[i][clk_align_pkg::OC_PD] ||
			chan_ff[C][clk_align_pkg::CH_PD] || !sleep_ff; // RULE14
		assign tpd_w = act_ff[clk_align_pkg::CT_DIST_PD]; // RULE13
		assign se_w = out_ff[i][clk_align_pkg::OC_SE];
		// Drivers stay static until the sequencer reaches run
		assign val_w = state_ff == clk_align_pkg::S_RUN ? lvl_ff[C] :
			chan_ff[C][clk_align_pkg::CH_INIT_HI]; // RULE10
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				drv_on_o[i] <= 1'b0;
				drv_p_o[i] <= 1'b0;
				drv_swing_o[2*i +: 2] <= 2'h0;
				safe_off_o[i] <= 1'b1;
				se_a_o[i] <= 1'b0;
				se_b_o[i] <= 1'b0;
				se_a_oe_o[i] <= 1'b0;
				se_b_oe_o[i] <= 1'b0;
			end else begin
				drv_on_o[i] <= !off_w && !tpd_w && !se_w;
				drv_p_o[i] <= val_w ^ out_ff[i][clk_align_pkg::OC_INV]; // RULE12
				drv_swing_o[2*i +: 2] <=
					out_ff[i][clk_align_pkg::OC_SWING_LSB +: 2]; // RULE12
				safe_off_o[i] <= off_w;
				se_a_o[i] <= val_w ^ out_ff[i][clk_align_pkg::OC_INV]; // RULE17
				se_b_o[i] <= val_w ^ out_ff[i][clk_align_pkg::OC_INV_B]; // RULE17
				se_a_oe_o[i] <= se_w && !off_w && !tpd_w &&
					out_ff[i][clk_align_pkg::OC_EN_A]; // RULE16
				se_b_oe_o[i] <= se_w && !off_w && !tpd_w &&
					out_ff[i][clk_align_pkg::OC_EN_B]; // RULE16
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			total_off_o <= 1'b0;
			align_busy_o <= 1'b1;
			storage_load_o <= 1'b0;
		end else begin
			total_off_o <= act_ff[clk_align_pkg::CT_DIST_PD];
			align_busy_o <= hold_w;
			storage_load_o <= state_ff == clk_align_pkg::S_LOAD && store_ff;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_pin_holds: assert property (!pin_s2_ff |-> hold_w) // RULE1
		else $error("Pin request did not hold alignment");
	a_restart_delay: assert property ( // RULE6
		$fell(any_src) |-> hold_w [*8] ##1 hold_w [*7])
		else $error("Channels released before pipeline delay");
	a_quiet_release: assert property ( // RULE6
		!any_src [*8] ##1 !any_src [*8] |-> !hold_w)
		else $error("Alignment held with no source");
	a_update_gates: assert property ( // RULE8
		!$stable(act_ff) && !$past(restore) |-> $past(upd))
		else $error("Soft control changed without update");
	// Ignoring channel must count or toggle every cycle, even under hold
	a_ignore_runs: assert property ( // RULE11
		chan_ff[1][clk_align_pkg::CH_IGNORE] &&
		!chan_ff[1][clk_align_pkg::CH_PD] && g_chan[1].dly_ff == 6'h00 |=>
		lvl_ff[1] != $past(lvl_ff[1]) ||
		g_chan[1].cnt_c_ff != $past(g_chan[1].cnt_c_ff))
		else $error("Ignoring channel was held");
	a_static_level: assert property ( // RULE9
		held_w[1] ##1 held_w[1] |-> lvl_ff[1] ==
		$past(chan_ff[1][clk_align_pkg::CH_INIT_HI]))
		else $error("Held channel not at preset level");
	a_total_off: assert property ( // RULE13
		act_ff[clk_align_pkg::CT_DIST_PD] |=> drv_on_o == 12'h000 &&
		se_a_oe_o == 12'h000 && se_b_oe_o == 12'h000)
		else $error("Driver on during total power-down");
	a_sleep_safe: assert property ( // RULE14
		!sleep_ff |=> safe_off_o == 12'hFFF && hold_w)
		else $error("Sleep did not power down safely");
	a_se_tristate: assert property ( // RULE16
		!out_ff[2][clk_align_pkg::OC_EN_A] |=> !se_a_oe_o[2])
		else $error("Disabled single-ended driver enabled");
	a_srst_clear: assert property ( // RULE23
		$fell(srst_pend) |-> $past(sclk_tick_i))
		else $error("Soft reset ended without serial clock");
	a_reset_pin: assert property ( // RULE3
		!rpin_ff |=> state_ff == clk_align_pkg::S_LOAD && hold_w)
		else $error("Pin reset did not start restore");
	a_cal_hold: assert property (cal_busy_i |=> hold_w) // RULE5
		else $error("Calibration did not hold alignment");
endmodule
`default_nettype wire

/* bench/host_pins_model.sv */
// Purpose: Host-side driver of the alignment, reset and sleep pins
// Assumes: pins change by non-blocking assignment after a rising edge
// Notes: pulse length set by caller, so answers may be quick or slow
`default_nettype none
module host_pins_model (
	input wire logic clk_i,
	output logic align_req_n_o,
	output logic chip_reset_n_o,
	output logic sleep_n_o,
	output logic cal_busy_o,
	output logic sclk_tick_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		align_req_n_o = 1'b1;
		chip_reset_n_o = 1'b1;
		sleep_n_o = 1'b1;
		cal_busy_o = 1'b0;
		sclk_tick_o = 1'b0;
	end
	task automatic drive(input int pin, input logic on);
		case (pin)
			0: align_req_n_o <= ~on;
			1: chip_reset_n_o <= ~on;
			2: sleep_n_o <= ~on;
			3: cal_busy_o <= on;
			default: sclk_tick_o <= on;
		endcase
	endtask
	// Active for len cycles, then released
	task automatic pulse(input int pin, input int len);
		@(posedge clk_i);
		drive(pin, 1'b1);
		repeat (len) @(posedge clk_i);
		drive(pin, 1'b0);
	endtask
endmodule
`default_nettype wire

/* bench/tb_out_align_ctrl.sv */
// Purpose: Self-checking bench for the alignment and reset control
// Assumes: boot and load counts shortened by parameters
// Notes: read data compared by a watcher against a queue of notes
`default_nettype none
module tb_out_align_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] SC = clk_align_pkg::SERCTL_OFF;
	localparam logic [7:0] CT = clk_align_pkg::CTRL_OFF;
	localparam logic [7:0] UP = clk_align_pkg::UPDATE_OFF;
	localparam logic [7:0] CB = clk_align_pkg::CHAN_BASE;
	localparam logic [7:0] OB = clk_align_pkg::OUT_BASE;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hF;
	logic [31:0] wdat = 32'h0000_0000;
	logic storage_sel = 1'b0;
	logic [31:0] rdat;
	logic ack, req_n, crst_n, slp_n, cal, tick, total_off, busy, sload;
	logic [3:0] chan;
	logic [11:0] drv_on, drv_p, safe_off, se_a, se_a_oe, se_b, se_b_oe;
	logic [23:0] swing;
	int n_fail = 0;
	int check_count = 0;
	logic [31:0] exp_q[$];
	always #5 clk_i = ~clk_i;
	host_pins_model host_pins_model_inst (.clk_i(clk_i),
		.align_req_n_o(req_n), .chip_reset_n_o(crst_n),
		.sleep_n_o(slp_n), .cal_busy_o(cal), .sclk_tick_o(tick));
	out_align_ctrl #(.POR_ALIGN_CYC(50), .POR_RUN_CYC(80), .LOAD_CYC(40))
		out_align_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.align_req_n_i(req_n), .chip_reset_n_i(crst_n),
		.chip_sleep_pin_n_i(slp_n), .storage_sel_i(storage_sel),
		.cal_busy_i(cal), .sclk_tick_i(tick), .chan_clk_o(chan),
		.drv_on_o(drv_on), .drv_p_o(drv_p), .drv_swing_o(swing),
		.safe_off_o(safe_off), .total_off_o(total_off), .se_a_o(se_a),
		.se_a_oe_o(se_a_oe), .se_b_o(se_b), .se_b_oe_o(se_b_oe),
		.align_busy_o(busy), .storage_load_o(sload));
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("wrong value %s exp %h got %h", nm, e, g);
			n_fail++;
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			n_fail++;
			end_of_test();
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0000_0000);
	endtask
	task automatic wt(input int k);
		repeat (k) @(posedge clk_i);
	endtask
	task automatic idle(input int lim, output int n);
		n = 0;
		while (busy !== 1'b0 && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		if (busy !== 1'b0) begin
			n_fail++;
			end_of_test();
		end
	endtask
	always @(posedge clk_i) begin
		if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0) begin
			if (exp_q.size() == 0) begin
				chk("unexpected read", 32'h0000_0000, 32'h0000_0001);
			end else begin
				chk("read data", exp_q.pop_front(), rdat);
			end
		end
	end
	initial begin
		int n;
		logic [1:0] s;
		logic v;
		logic t;
		void'($urandom(9422));
		wt(16);
		rst_i <= 1'b0;
		wt(2);
		chk("boot hold", 1, 32'(busy));
		idle(400, n);
		chk("boot time", 1, 32'(n >= 50));
		rd(OB, 32'h0000_0004);
		rd(CB, 32'h0000_0000);
		wr(8'hF0, 32'h0000_00FF);
		rd(8'hF0, 32'h0000_0000);
		$display("test reset values done");
		wr(CB, 32'h0000_1000);
		wr(CB + 8'h04, 32'h0000_2000);
		fork
			host_pins_model_inst.pulse(0, 12);
			begin
				wt(6);
				chk("pin hold", 1, 32'(busy));
				chk("ch0 static", 7, 32'(drv_p[2:0]));
				chk("ch2 static", 0, 32'(chan[2]));
				t = 1'b0;
				s[0] = chan[1];
				repeat (4) begin
					wt(1);
					t = t | (chan[1] ^ s[0]);
				end
				chk("ignored runs", 1, 32'(t));
			end
		join
		idle(40, n);
		chk("restart", 1, 32'(n >= 14 && n <= 21));
		$display("test pin align done");
		wr(CT, 32'h0000_0001);
		wt(4);
		chk("no update", 0, 32'(busy));
		wr(UP, 32'h0000_0001);
		wt(4);
		chk("soft align", 1, 32'(busy));
		rd(CT, 32'h0000_0005);
		wr(CT, 32'h0000_0000);
		wt(20);
		chk("clear waits", 1, 32'(busy));
		wr(UP, 32'h0000_0001);
		idle(40, n);
		wr(CT, 32'h0000_0002);
		wr(UP, 32'h0000_0001);
		wt(2);
		chk("total off", 1, 32'(total_off));
		chk("pd align", 1, 32'(busy));
		chk("total drv", 0, 32'(drv_on));
		wr(CT, 32'h0000_0000);
		wr(UP, 32'h0000_0001);
		idle(40, n);
		chk("total on", 0, 32'(total_off));
		chk("drv back", 32'h0000_0FFF, 32'(drv_on));
		$display("test soft align done");
		for (int i = 0; i < 12; i++) begin
			s = 2'($urandom());
			v = 1'($urandom());
			wr(OB + 8'(4 * i), {28'h0000_000, v, s, 1'b0});
			rd(OB + 8'(4 * i), {28'h0000_000, v, s, 1'b0});
			chk("swing", 32'(s), 32'(swing[2 * i +: 2]));
		end
		wr(OB + 8'h14, 32'h0000_0001);
		wt(2);
		chk("out pd", 1, 32'(safe_off[5]));
		wr(CB + 8'h0C, 32'h0000_4000);
		wt(2);
		chk("chan pd", 7, 32'(safe_off[11:9]));
		fork
			host_pins_model_inst.pulse(2, 10);
			begin
				wt(5);
				chk("sleep off", 32'h0000_0FFF, 32'(safe_off));
				chk("sleep hold", 1, 32'(busy));
			end
		join
		idle(60, n);
		$display("test drivers done");
		wr(OB, 32'h0000_0010);
		rd(OB, 32'h0000_0070);
		chk("se on", 3, 32'({se_a_oe[0], se_b_oe[0]}));
		wr(OB, 32'h0000_0030);
		wt(2);
		chk("b off", 2, 32'({se_a_oe[0], se_b_oe[0]}));
		wr(OB, 32'h0000_0078);
		wt(2);
		chk("pol mix", 1, 32'(se_a[0] ^ se_b[0]));
		wr(OB, 32'h0000_00F8);
		wt(2);
		chk("pol same", 0, 32'(se_a[0] ^ se_b[0]));
		$display("test single ended done");
		wr(SC, 32'h0000_00A5);
		wt(3);
		chk("srst hold", 1, 32'(busy));
		rd(SC, 32'h0000_00A5);
		host_pins_model_inst.pulse(4, 1);
		wt(2);
		rd(SC, 32'h0000_0081);
		rd(OB, 32'h0000_0004);
		idle(400, n);
		$display("test soft reset done");
		storage_sel <= 1'b1;
		wr(OB + 8'h04, 32'h0000_000D);
		fork
			host_pins_model_inst.pulse(1, 5);
			begin
				wt(4);
				chk("reset hold", 1, 32'(busy));
			end
		join
		wt(2);
		chk("loading", 1, 32'(sload));
		idle(400, n);
		chk("load time", 1, 32'(n >= 40));
		rd(OB + 8'h04, 32'h0000_0004);
		storage_sel <= 1'b0;
		host_pins_model_inst.pulse(1, 3);
		wt(2);
		chk("no load", 0, 32'(sload));
		idle(400, n);
		$display("test pin reset done");
		fork
			host_pins_model_inst.pulse(3, 8);
			begin
				wt(5);
				chk("cal hold", 1, 32'(busy));
			end
		join
		idle(40, n);
		$display("test calibration done");
		end_of_test();
	end
endmodule
`default_nettype wire
